/* inc/gswc_pkg.sv */
package gswc_pkg;

  // Register addresses on the serial register port
  localparam logic [6:0] GSWC_ADDR_STATUS  = 7'h01;
  localparam logic [6:0] GSWC_ADDR_COUNTER = 7'h02;

  // Status flag bit positions
  localparam int GSWC_BIT_CHIP_RESET   = 0;
  localparam int GSWC_BIT_M0_SHUTDOWN  = 1;
  localparam int GSWC_BIT_REG_UNDERV   = 2;
  localparam int GSWC_BIT_MAP_DEFAULTS = 3;
  localparam int GSWC_BIT_SUP_UNDERV   = 4;
  localparam int GSWC_BIT_M1_SHUTDOWN  = 5;
  localparam int GSWC_FLAG_W           = 6;

  // Reset values
  localparam logic [5:0] GSWC_STATUS_RST  = 6'h09;
  localparam logic [7:0] GSWC_COUNTER_RST = 8'h00;

  // Register access request from the serial front end
  typedef struct packed {
    logic        valid;  // One-cycle access strobe
    logic        write;  // High for write, low for read
    logic [6:0]  addr;   // Register address
    logic [31:0] wdata;  // Write data
  } gswc_req_type;

  // Hazard inputs from the analog and driver blocks
  typedef struct packed {
    logic m0_shutdown;   // Motor 0 driver shut down
    logic m1_shutdown;   // Motor 1 driver shut down
    logic m0_overtemp;   // Motor 0 temperature above limit
    logic m1_overtemp;   // Motor 1 temperature above limit
    logic sup_underv;    // Motor supply undervoltage
    logic reg_underv;    // Regulator undervoltage
    logic quiesce_exit;  // Leaving low-power state
    logic map_defaults;  // Register map returned to defaults
  } gswc_evt_type;

endpackage : gswc_pkg

/* rtl/gswc_regs.sv */
`timescale 1ns/10ps
module gswc_regs
  import gswc_pkg::*;
(
  // Clock and reset
  input  wire logic         mclk_in,
  input  wire logic         rst_n_in,
  // Register access from serial front end
  input  wire gswc_req_type req_in,
  input  wire logic         req_ok_in,
  input  wire logic         spi_mode_in,
  output logic [31:0]       rdata_out,
  // Hazard events
  input  wire gswc_evt_type evt_in,
  // Driver enable to bridges
  output logic              drv_enable_out
);

  ////////////////////////////////////////////////////////////////////////
  // Decode
  // The serial front end hands over one strobe per checked frame.
  // req_ok_in tells a good frame from a damaged one; only good writes
  // may touch the flags or advance the counter.
  // Reads are decoded here as well but alter nothing except rdata_out, so a
  // host may poll as often as it likes without side effects.
  // The SPI select is a level and is assumed stable around a frame.

  logic [5:0] flags;       // Sticky status flags
  logic [7:0] wr_count;    // Successful UART write count
  logic [5:0] set_vec;     // Setting events this cycle
  logic [5:0] clr_vec;     // Clear requests this cycle
  logic [5:0] next_flags;  // Next flag state
  logic       status_wr;   // Good write to status
  logic       count_hit;   // Counted write

  // Write to status register only when the frame checked out
  assign status_wr = req_in.valid & req_in.write & req_ok_in &
                     (req_in.addr == GSWC_ADDR_STATUS);

  // Any good UART write counts, whatever its target
  assign count_hit = req_in.valid & req_in.write & req_ok_in & ~spi_mode_in;

  ////////////////////////////////////////////////////////////////////////
  // Flag set and clear
  // Every flag is sticky: a cause that comes and goes leaves its mark
  // until the host writes a one to that bit position.
  // Hazard: the host clear and a fresh cause may meet in one cycle.
  // The cause wins so that no event is ever silently swallowed; the
  // host simply sees the flag again on its next poll.
  // Chip reset has no event source after reset; only the reset value
  // sets it, and one clear removes it for good.

  // Event vector, one bit per flag
  always_comb begin
    set_vec = '0;
    set_vec[GSWC_BIT_M0_SHUTDOWN]  = evt_in.m0_shutdown;
    set_vec[GSWC_BIT_M1_SHUTDOWN]  = evt_in.m1_shutdown;
    set_vec[GSWC_BIT_SUP_UNDERV]   = evt_in.sup_underv;
    set_vec[GSWC_BIT_MAP_DEFAULTS] = evt_in.map_defaults;
    set_vec[GSWC_BIT_REG_UNDERV]   = evt_in.reg_underv |
                                     evt_in.quiesce_exit;
  end

  // Clear vector; hot drivers refuse the clear
  always_comb begin
    clr_vec = status_wr ? req_in.wdata[GSWC_FLAG_W-1:0] : '0;
    if (evt_in.m0_overtemp) begin
      clr_vec[GSWC_BIT_M0_SHUTDOWN] = 1'b0;
    end
    if (evt_in.m1_overtemp) begin
      clr_vec[GSWC_BIT_M1_SHUTDOWN] = 1'b0;
    end
  end

  // Set beats clear so a coincident event is not lost
  assign next_flags = (flags & ~clr_vec) | set_vec;

  // Flag register; reset value marks chip and map reset
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flags <= GSWC_STATUS_RST;
    end else begin
      flags <= next_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write counter
  // Counts every good UART write, whatever its target address, so the
  // host can compare its own tally against ours and spot lost frames.
  // Frozen while SPI is selected: that link has its own integrity.
  // No saturation and no overflow flag; the host compares modulo 256.
  // Limitation: a burst of more than 255 unchecked writes aliases.

  // Plain 8-bit increment wraps naturally
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_count <= GSWC_COUNTER_RST;
    end else if (count_hit) begin
      wr_count <= wr_count + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data and driver enable
  // Read data is registered so the output never glitches with the bus;
  // the price is one cycle of latency, which the front end absorbs.
  // The word stands until the next read replaces it.
  // The bridge enable follows the regulator one cycle late, which is
  // far shorter than any undervoltage the bridges could suffer from.

  // Registered read data, presented the cycle after a read
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (req_in.valid && !req_in.write) begin
      unique case (req_in.addr)
        GSWC_ADDR_STATUS:  rdata_out <= {26'h0, flags};
        GSWC_ADDR_COUNTER: rdata_out <= {24'h0, wr_count};
        default:           rdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // Bridges off for as long as the regulator is low
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      drv_enable_out <= 1'b0;
    end else begin
      drv_enable_out <= ~evt_in.reg_underv;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // Each property samples at the rising clock edge and is silenced
  // during reset, where the flags are forced to their reset value.
  // Set checks look one cycle after the cause; hold checks look one
  // cycle after any cycle without a clear of that bit, or for chip reset after any cycle without a status write.
  // Clear checks only fire when no cause and no hot bridge interfere,
  // so they stay quiet in the priority and refusal cases.
  // Read checks compare the registered word against the state that
  // stood at the edge which took the read.
  // The increment check uses $past so it holds across the wrap.
  // Covers at the end mark the scenarios that must be exercised.

  chk_m0_set: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    evt_in.m0_shutdown |=> flags[GSWC_BIT_M0_SHUTDOWN])
    else $error("motor0 shutdown flag not set");
  chk_hot_clear: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    flags[GSWC_BIT_M1_SHUTDOWN] && evt_in.m1_overtemp |=> flags[GSWC_BIT_M1_SHUTDOWN])
    else $error("motor1 flag cleared while hot");
  chk_sup_set: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    evt_in.sup_underv |=> flags[GSWC_BIT_SUP_UNDERV])
    else $error("supply flag not set");
  chk_ldo_drv: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    evt_in.reg_underv |=> !drv_enable_out && flags[GSWC_BIT_REG_UNDERV])
    else $error("regulator undervoltage not handled");
  chk_quiesce_set: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    evt_in.quiesce_exit |=> flags[GSWC_BIT_REG_UNDERV])
    else $error("quiesce exit flag not set");
  chk_count_inc: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    count_hit |=> wr_count == $past(wr_count) + 8'h01)
    else $error("counter did not advance");
  chk_count_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (req_in.valid && !req_in.write) || spi_mode_in |=> $stable(wr_count))
    else $error("counter moved on read or spi");
  chk_count_wrap: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    count_hit && wr_count == 8'hff |=> wr_count == 8'h00)
    else $error("counter did not wrap");
  chk_sticky_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    flags[GSWC_BIT_CHIP_RESET] && !status_wr |=> flags[GSWC_BIT_CHIP_RESET])
    else $error("flag dropped without clear");
  chk_set_wins: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    status_wr && req_in.wdata[GSWC_BIT_MAP_DEFAULTS] && evt_in.map_defaults
    |=> flags[GSWC_BIT_MAP_DEFAULTS])
    else $error("clear beat event");

  // Second motor follows the same shutdown path as the first
  chk_m1_set: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    evt_in.m1_shutdown |=> flags[GSWC_BIT_M1_SHUTDOWN])
    else $error("motor1 shutdown flag not set");

  // A hot motor 0 bridge keeps its flag even under a clear
  chk_hot_hold0: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    flags[GSWC_BIT_M0_SHUTDOWN] && evt_in.m0_overtemp |=> flags[GSWC_BIT_M0_SHUTDOWN])
    else $error("motor0 flag cleared while hot");

  // Register map defaults event
  chk_map_set: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    evt_in.map_defaults |=> flags[GSWC_BIT_MAP_DEFAULTS])
    else $error("map defaults flag not set");

  // Clearing the chip reset flag must take effect
  chk_clear_done: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    status_wr && req_in.wdata[GSWC_BIT_CHIP_RESET] |=> !flags[GSWC_BIT_CHIP_RESET])
    else $error("reset flag not cleared");

  // A cool motor 0 bridge lets its flag go
  chk_clear_m0: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    status_wr && req_in.wdata[GSWC_BIT_M0_SHUTDOWN] && !evt_in.m0_overtemp &&
    !evt_in.m0_shutdown |=> !flags[GSWC_BIT_M0_SHUTDOWN])
    else $error("motor0 flag not cleared");

  // A cool motor 1 bridge lets its flag go
  chk_clear_m1: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    status_wr && req_in.wdata[GSWC_BIT_M1_SHUTDOWN] && !evt_in.m1_overtemp &&
    !evt_in.m1_shutdown |=> !flags[GSWC_BIT_M1_SHUTDOWN])
    else $error("motor1 flag not cleared");

  // Supply flag clears on a one
  chk_clear_sup: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    status_wr && req_in.wdata[GSWC_BIT_SUP_UNDERV] && !evt_in.sup_underv
    |=> !flags[GSWC_BIT_SUP_UNDERV])
    else $error("supply flag not cleared");

  // Regulator flag clears once both of its causes are gone
  chk_clear_reg: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    status_wr && req_in.wdata[GSWC_BIT_REG_UNDERV] && !evt_in.reg_underv &&
    !evt_in.quiesce_exit |=> !flags[GSWC_BIT_REG_UNDERV])
    else $error("regulator flag not cleared");

  // A zero in the write data leaves the supply flag alone
  chk_zero_ignored: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    flags[GSWC_BIT_SUP_UNDERV] && !(status_wr && req_in.wdata[GSWC_BIT_SUP_UNDERV])
    |=> flags[GSWC_BIT_SUP_UNDERV])
    else $error("supply flag dropped without clear");

  // Regulator flag is latched past the end of its cause
  chk_reg_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    flags[GSWC_BIT_REG_UNDERV] && !(status_wr && req_in.wdata[GSWC_BIT_REG_UNDERV])
    |=> flags[GSWC_BIT_REG_UNDERV])
    else $error("regulator flag dropped without clear");

  // Motor 0 flag is sticky
  chk_m0_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    flags[GSWC_BIT_M0_SHUTDOWN] && !(status_wr && req_in.wdata[GSWC_BIT_M0_SHUTDOWN])
    |=> flags[GSWC_BIT_M0_SHUTDOWN])
    else $error("motor0 flag dropped without clear");

  // Motor 1 flag is sticky
  chk_m1_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    flags[GSWC_BIT_M1_SHUTDOWN] && !(status_wr && req_in.wdata[GSWC_BIT_M1_SHUTDOWN])
    |=> flags[GSWC_BIT_M1_SHUTDOWN])
    else $error("motor1 flag dropped without clear");

  // Map defaults flag is sticky
  chk_map_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    flags[GSWC_BIT_MAP_DEFAULTS] && !(status_wr && req_in.wdata[GSWC_BIT_MAP_DEFAULTS])
    |=> flags[GSWC_BIT_MAP_DEFAULTS])
    else $error("map flag dropped without clear");

  // A damaged frame never advances the counter
  chk_bad_frame: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    req_in.valid && req_in.write && !req_ok_in |=> $stable(wr_count))
    else $error("counter moved on bad frame");

  // Nothing but a counted write moves the counter
  chk_count_idle: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !count_hit |=> $stable(wr_count))
    else $error("counter moved without a write");

  // SPI selection freezes the counter even on good writes
  chk_spi_freeze: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    spi_mode_in && req_in.valid && req_in.write && req_ok_in |=> $stable(wr_count))
    else $error("counter moved in spi mode");

  // Bridges come back once the regulator is good
  chk_drv_back: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !evt_in.reg_underv |=> drv_enable_out)
    else $error("bridges not enabled");

  // Counter read returns the value at the taking edge
  chk_rd_counter: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    req_in.valid && !req_in.write && req_in.addr == GSWC_ADDR_COUNTER
    |=> rdata_out == {24'h0, $past(wr_count)})
    else $error("counter read mismatch");

  // Status read returns the flags at the taking edge
  chk_rd_status: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    req_in.valid && !req_in.write && req_in.addr == GSWC_ADDR_STATUS
    |=> rdata_out == {26'h0, $past(flags)})
    else $error("status read mismatch");

  cov_clear_reset: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
    status_wr ##1 !flags[GSWC_BIT_CHIP_RESET]);
  cov_wrap: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
    count_hit && wr_count == 8'hff);
  cov_hot_refuse: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
    status_wr && evt_in.m0_overtemp && flags[GSWC_BIT_M0_SHUTDOWN]);

  // Motor 1 clear refused while hot
  cov_hot_m1: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
    status_wr && evt_in.m1_overtemp && flags[GSWC_BIT_M1_SHUTDOWN]);

  // Event and clear of one flag in the same cycle
  cov_prio: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
    status_wr && req_in.wdata[GSWC_BIT_M1_SHUTDOWN] && evt_in.m1_shutdown);

endmodule : gswc_regs

/* test/gswc_host.sv */
`timescale 1ns/10ps
// Host model: one-cycle register accesses, bus scrambled when idle
module gswc_host
  import gswc_pkg::*;
(
  // Clock
  input  wire logic    clk_in,
  // Request to the block
  output gswc_req_type req_out,
  output logic         ok_out
);
  initial begin
    req_out = '0;
    ok_out  = 1'b0;
  end
  // Hold for one sampling edge, then invert so stale data never looks valid
  task xfer(input logic w, input logic [6:0] a, input logic [31:0] d, input logic ok);
    @(posedge clk_in);
    #1;
    req_out = '{1'b1, w, a, d};
    ok_out  = ok;
    @(posedge clk_in);
    #1;
    req_out = '{1'b0, 1'b0, ~a, ~d};
    ok_out  = ~ok;
  endtask : xfer
endmodule : gswc_host

/* test/global_status_and_write_counter_test.sv */
`timescale 1ns/10ps
module global_status_and_write_counter_test
  import gswc_pkg::*;
;
  logic mclk_in, rst_n_in, req_ok_in, spi_mode_in, drv_enable_out;
  gswc_req_type req_in;
  gswc_evt_type evt_in;
  logic [31:0] rdata_out;
  logic [7:0] cnt;      // Expected count of good UART writes
  int error_cnt, n_tests;
  gswc_host gswc_host_i (.clk_in(mclk_in), .req_out(req_in), .ok_out(req_ok_in));
  gswc_regs gswc_regs_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .req_in(req_in),
    .req_ok_in(req_ok_in), .spi_mode_in(spi_mode_in), .rdata_out(rdata_out),
    .evt_in(evt_in), .drv_enable_out(drv_enable_out));
  ////////////////////////////////////////////////////////////////////////
  task fail(input logic bad);
    n_tests++;
    if (bad) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: value mismatch", $time);
    end
  endtask : fail
  task rd(input logic [6:0] a, input logic [31:0] e);
    gswc_host_i.xfer(1'b0, a, 32'h0, 1'b1);
    fail(rdata_out !== e);
  endtask : rd
  // Model count only for good writes outside SPI mode
  task wr(input logic [6:0] a, input logic [31:0] d, input logic ok);
    gswc_host_i.xfer(1'b1, a, d, ok);
    if (ok && !spi_mode_in) cnt++;
  endtask : wr
  // One-cycle event pulse; drive enable must drop right after undervoltage
  task ev(input gswc_evt_type e);
    @(posedge mclk_in);
    #1;
    evt_in = e;
    @(posedge mclk_in);
    #1;
    fail(drv_enable_out !== !e.reg_underv);
    evt_in = '0;
  endtask : ev
  task t_clear;
    wr(7'h01, 32'h0, 1'b1);
    rd(7'h01, 32'h9);
    wr(7'h01, 32'h9, 1'b0);
    rd(7'h05, 32'h0);
    rd(7'h02, {24'h0, cnt});
    wr(7'h01, 32'h9, 1'b1);
    rd(7'h01, 32'h0);
    spi_mode_in = 1'b1;
    wr(7'h01, 32'h0, 1'b1);
    rd(7'h02, {24'h0, cnt});
    spi_mode_in = 1'b0;
  endtask : t_clear
  task t_events;
    ev('{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1});
    rd(7'h01, 32'h3e);
    wr(7'h01, 32'h3e, 1'b1);
    ev('{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0});
    rd(7'h01, 32'h4);
    wr(7'h01, 32'h4, 1'b1);
  endtask : t_events
  task t_hot;
    ev('{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0});
    evt_in.m0_overtemp = 1'b1;
    evt_in.m1_overtemp = 1'b1;
    wr(7'h01, 32'h22, 1'b1);
    rd(7'h01, 32'h22);
    evt_in = '0;
    wr(7'h01, 32'h22, 1'b1);
    rd(7'h01, 32'h0);
  endtask : t_hot
  // Set event lands on the same edge as its clear
  task t_prio;
    fork
      wr(7'h01, 32'h20, 1'b1);
      begin
        @(posedge mclk_in);
        #1;
        evt_in.m1_shutdown = 1'b1;
        @(posedge mclk_in);
        #1;
        evt_in = '0;
      end
    join
    rd(7'h01, 32'h20);
  endtask : t_prio
  task t_wrap;
    while (cnt != 8'hff) wr(7'h02, 32'h0, 1'b1);
    rd(7'h02, 32'hff);
    wr(7'h03, 32'h0, 1'b1);
    rd(7'h02, 32'h0);
  endtask : t_wrap
  task wrap_up;
    $display("Errors = %0d, tests = %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  // Bounded run: the whole sequence needs about 560 cycles
  initial begin
    #100000;
    error_cnt++;
    wrap_up;
  end
  initial begin
    {rst_n_in, spi_mode_in, cnt} = '0;
    evt_in = '0;
    repeat (16) @(posedge mclk_in);
    #1;
    rst_n_in = 1'b1;
    rd(7'h02, 32'h0);
    t_clear;
    t_events;
    t_hot;
    t_prio;
    t_wrap;
    wrap_up;
  end
endmodule : global_status_and_write_counter_test
